/* File: ppr_regulator.sv */
// Process PID regulator: APB registers, sampling, PID math and dormancy.
//
// Behaviour
// - Feedback from channel 0..8: three analog, three sums, pulse, buses.
// - Positive output: feedback above preset lowers output frequency.
// - Negative output: feedback above preset raises output frequency.
// - Proportional term is gain times deviation; gain 0.00..100.00.
// - Integral term accumulates deviation, inverse to integral time.
// - Differential term follows deviation change, grows with its time.
// - Exactly one sample and computation per sampling period.
// - While deviation lies within the limit, output is held.
// - Valid reference and feedback at or below threshold runs loss timer.
// - Loss timer beyond loss time raises the feedback-offline alarm.
// - A zero dormancy delay disables sleeping.
// - Steady in band: hold for the delay, ramp to zero, then sleep.
// - Wake below wake value (positive) or above it (negative).
// - After waking, output rises from zero under regulation.
// - Reference and feedback are relative values on one 0..100 scale.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`default_nettype none
module ppr_regulator
  import ppr_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ppr_fb_t fb_i,
  input wire logic [15:0] preset_i,
  input wire logic ref_valid_i,
  output logic [15:0] freq_cmd_o,
  output logic fb_alarm_o,
  output logic dormant_o
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int DW = DIV_W;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ppr_cfg_t cfg_reg;
  ppr_calc_t cs_state;
  ppr_doze_t ds_state;
  logic [TW-1:0] tick_cnt_reg;
  logic [3:0] tenth_cnt_reg;
  logic [15:0] samp_cnt_reg;
  logic [15:0] fb_reg;
  logic [15:0] u_reg;
  logic [15:0] hold_cnt_reg;
  logic [15:0] loss_cnt_reg;
  logic signed [16:0] err_reg;
  logic signed [16:0] err1_reg;
  logic signed [16:0] err2_reg;
  logic signed [DW-1:0] iterm_reg;
  logic signed [DW-1:0] dterm_reg;
  logic signed [DW-1:0] du_reg;
  logic start_reg;
  logic apply_reg;
  logic alarm_reg;
  logic [31:0] rd_val;
  logic tick, tenth, samp_due, sample_go, calc_go, wr_go;
  logic [15:0] fb_now;
  logic signed [16:0] err_now;
  logic [16:0] err_mag;
  logic in_band, wake_hit, fb_low, loss_set;
  logic signed [DW-1:0] e0, e1, e2, u_sum, div_num, div_quo;
  logic [15:0] div_den;
  logic div_done;

  // Register offsets that the bus may address.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_FB);
  endfunction

  // Zero is not a legal time divisor, so it is stored as the least step.
  function automatic logic [15:0] nz(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  // Feedback channel picker; unknown codes read as no feedback.
  function automatic logic [15:0] fb_pick(input logic [3:0] s,
                                          input ppr_fb_t f);
    unique case (s)
      4'h0: return f.analog_input_a;
      4'h1: return f.analog_input_b;
      4'h2: return f.analog_input_c;
      4'h3: return ppr_sat_add(f.analog_input_a, f.analog_input_b);
      4'h4: return ppr_sat_add(f.analog_input_b, f.analog_input_c);
      4'h5: return ppr_sat_add(f.analog_input_c, f.analog_input_a);
      4'h6: return f.pulse_frequency_input;
      4'h7: return f.bus_a;
      4'h8: return f.bus_b;
      default: return 16'h0000;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // APB slave. One wait state: pready rises in the second access cycle.

  assign wr_go = psel_i & penable_i & pready_o & pwrite_i;

  // Answer, read data and error for unmapped offsets are all registered.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= psel_i & penable_i & ~pready_o;
      if (psel_i & penable_i & ~pready_o) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
        pslverr_o <= ~addr_hit(paddr_i);
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // Read view of settings and of the regulator's own state.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr_i)
      OFS_CTRL: rd_val = {26'h0, cfg_reg.sel, cfg_reg.pol, cfg_reg.en};
      OFS_KP: rd_val = {16'h0, cfg_reg.kp};
      OFS_TI: rd_val = {16'h0, cfg_reg.ti};
      OFS_TD: rd_val = {16'h0, cfg_reg.td};
      OFS_T: rd_val = {16'h0, cfg_reg.t};
      OFS_BAND: rd_val = {16'h0, cfg_reg.band};
      OFS_LTHR: rd_val = {16'h0, cfg_reg.loss_thr};
      OFS_LTIME: rd_val = {16'h0, cfg_reg.loss_time};
      OFS_WAKE: rd_val = {16'h0, cfg_reg.wake};
      OFS_SLEEP: rd_val = {16'h0, cfg_reg.sleep};
      OFS_STAT: rd_val = {24'h0, ds_state, 1'b0, ~cs_state[0],
                          ds_state[3], alarm_reg};
      OFS_OUT: rd_val = {16'h0, u_reg};
      OFS_FB: rd_val = {16'h0, fb_reg};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Settings. Percent fields are tenths, times hundredths or tenths of s.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= CFG_RST;
    end else if (ce_i && wr_go) begin
      case (paddr_i)
        OFS_CTRL: begin
          cfg_reg.en <= pwdata_i[0];
          cfg_reg.pol <= pwdata_i[1];
          cfg_reg.sel <= pwdata_i[5:2];
        end
        OFS_KP: cfg_reg.kp <= pwdata_i[15:0];
        OFS_TI: cfg_reg.ti <= nz(pwdata_i[15:0]);
        OFS_TD: cfg_reg.td <= pwdata_i[15:0];
        OFS_T: cfg_reg.t <= nz(pwdata_i[15:0]);
        OFS_BAND: cfg_reg.band <= pwdata_i[15:0];
        OFS_LTHR: cfg_reg.loss_thr <= pwdata_i[15:0];
        OFS_LTIME: cfg_reg.loss_time <= pwdata_i[15:0];
        OFS_WAKE: cfg_reg.wake <= pwdata_i[15:0];
        OFS_SLEEP: cfg_reg.sleep <= pwdata_i[15:0];
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Time base: 10 ms tick and 100 ms tenth, both frozen with ce_i.

  assign tick = ce_i && (tick_cnt_reg == TW'(TICK_CYC - 1));
  assign tenth = tick && (tenth_cnt_reg == 4'(TICKS_PER_TENTH - 1));
  assign samp_due = tick && cfg_reg.en
                    && (samp_cnt_reg >= cfg_reg.t - 16'h0001);
  // A due sample waits for a busy computation so none is doubled.
  assign sample_go = samp_due && (cs_state == CS_IDLE);

  // Tick and tenth dividers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= '0;
      tenth_cnt_reg <= 4'h0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
      if (tick) begin
        tenth_cnt_reg <= tenth ? 4'h0 : tenth_cnt_reg + 4'h1;
      end
    end
  end

  // Sampling period counter in ticks.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp_cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (!cfg_reg.en || sample_go) begin
        samp_cnt_reg <= 16'h0000;
      end else if (tick && !samp_due) begin
        samp_cnt_reg <= samp_cnt_reg + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Deviation. Preset and feedback share the same tenths scale.

  assign fb_now = fb_pick(cfg_reg.sel, fb_i);
  // Sign is flipped for negative output so both modes drive u alike.
  assign err_now = cfg_reg.pol
                   ? $signed({1'b0, fb_now}) - $signed({1'b0, preset_i})
                   : $signed({1'b0, preset_i}) - $signed({1'b0, fb_now});
  assign err_mag = err_now[16] ? 17'(-err_now) : err_now;
  assign in_band = err_mag <= {1'b0, cfg_reg.band};

  // Sample and deviation history, taken once per period.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_reg <= 16'h0000;
      err_reg <= '0;
      err1_reg <= '0;
      err2_reg <= '0;
    end else if (ce_i && sample_go) begin
      fb_reg <= fb_now;
      err_reg <= err_now;
      err1_reg <= err_reg;
      err2_reg <= err1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Incremental PID: du = Kp*(de + e*T/Ti + (e-2e1+e2)*Td/T) / 100.
  // Truncation drops integral steps below one tenth percent; a wide T/Ti
  // ratio keeps that loss small.

  assign calc_go = sample_go && !in_band && (ds_state == DS_RUN);
  assign e0 = DW'(err_reg);
  assign e1 = DW'(err1_reg);
  assign e2 = DW'(err2_reg);

  // Divider operands per phase.
  always_comb begin
    div_num = '0;
    div_den = GAIN_ONE;
    unique case (cs_state)
      CS_DIVI: begin
        div_num = DW'(e0 * $signed({1'b0, cfg_reg.t}));
        div_den = cfg_reg.ti;
      end
      CS_DIVD: begin
        div_num = DW'((e0 - e1 - e1 + e2)
                      * $signed({1'b0, cfg_reg.td}));
        div_den = cfg_reg.t;
      end
      CS_DIVP: begin
        div_num = DW'((e0 - e1 + iterm_reg + dterm_reg)
                      * $signed({1'b0, cfg_reg.kp}));
        div_den = GAIN_ONE;
      end
      default: div_num = '0;
    endcase
  end

  ppr_div #(
    .W(DW)
  ) u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(start_reg),
    .num_i(div_num),
    .den_i(div_den),
    .quo_o(div_quo),
    .done_o(div_done)
  );

  // Computation sequencer: three divisions, then one apply pulse.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_state <= CS_IDLE;
      start_reg <= 1'b0;
      apply_reg <= 1'b0;
      iterm_reg <= '0;
      dterm_reg <= '0;
      du_reg <= '0;
    end else if (ce_i) begin
      start_reg <= 1'b0;
      apply_reg <= 1'b0;
      unique case (cs_state)
        CS_IDLE: if (calc_go) begin
          cs_state <= CS_DIVI;
          start_reg <= 1'b1;
        end
        CS_DIVI: if (div_done) begin
          iterm_reg <= div_quo;
          cs_state <= CS_DIVD;
          start_reg <= 1'b1;
        end
        CS_DIVD: if (div_done) begin
          dterm_reg <= div_quo;
          cs_state <= CS_DIVP;
          start_reg <= 1'b1;
        end
        CS_DIVP: if (div_done) begin
          du_reg <= div_quo;
          cs_state <= CS_IDLE;
          apply_reg <= 1'b1;
        end
        default: cs_state <= CS_IDLE;
      endcase
    end
  end

  assign u_sum = $signed({24'h0, u_reg}) + du_reg;

  // Output command, clamped to 0..100 percent; ramp pulls it to zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      u_reg <= 16'h0000;
    end else if (ce_i) begin
      if (!cfg_reg.en) begin
        u_reg <= 16'h0000;
      end else if (apply_reg && ds_state == DS_RUN) begin
        if (u_sum < 0) begin
          u_reg <= 16'h0000;
        end else if (u_sum > $signed({24'h0, PCT_FULL})) begin
          u_reg <= PCT_FULL;
        end else begin
          u_reg <= u_sum[15:0];
        end
      end else if (ds_state == DS_RAMP && tick) begin
        u_reg <= (u_reg > RAMP_STEP) ? u_reg - RAMP_STEP
                                     : 16'h0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Dormancy. Hold time is counted in tenths of a second.

  assign wake_hit = cfg_reg.pol ? (fb_now > cfg_reg.wake)
                                : (fb_now < cfg_reg.wake);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ds_state <= DS_RUN;
      hold_cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (!cfg_reg.en) begin
        ds_state <= DS_RUN;
      end else begin
        unique case (ds_state)
          DS_RUN: if (sample_go && in_band && cfg_reg.sleep != 16'h0000) begin
            ds_state <= DS_HOLD;
            hold_cnt_reg <= 16'h0000;
          end
          DS_HOLD: begin
            if (cfg_reg.sleep == 16'h0000 || (sample_go && !in_band)) begin
              ds_state <= DS_RUN;
            end else if (tenth) begin
              hold_cnt_reg <= hold_cnt_reg + 16'h0001;
              if (hold_cnt_reg + 16'h0001 >= cfg_reg.sleep) begin
                ds_state <= DS_RAMP;
              end
            end
          end
          DS_RAMP: if (u_reg == 16'h0000) ds_state <= DS_SLEEP;
          DS_SLEEP: if (sample_go && wake_hit) begin
            ds_state <= DS_RUN;
          end
          default: ds_state <= DS_RUN;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Feedback loss watch, on the live feedback so a dead wire shows early.

  assign fb_low = ref_valid_i && (fb_now <= cfg_reg.loss_thr);
  assign loss_set = fb_low && (loss_cnt_reg > cfg_reg.loss_time);

  // Loss timer in tenths, saturating.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loss_cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (!fb_low) begin
        loss_cnt_reg <= 16'h0000;
      end else if (tenth && loss_cnt_reg != 16'hFFFF) begin
        loss_cnt_reg <= loss_cnt_reg + 16'h0001;
      end
    end
  end

  // Sticky alarm, write one to clear; a new loss wins over the clear.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_reg <= 1'b0;
    end else if (ce_i) begin
      if (loss_set) begin
        alarm_reg <= 1'b1;
      end else if (wr_go && paddr_i == OFS_STAT && pwdata_i[0]) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  // Pin outputs, one flop behind their state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_cmd_o <= 16'h0000;
      fb_alarm_o <= 1'b0;
      dormant_o <= 1'b0;
    end else if (ce_i) begin
      freq_cmd_o <= u_reg;
      fb_alarm_o <= alarm_reg;
      dormant_o <= (ds_state == DS_SLEEP);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  fb_select_a: assert property (
    (sample_go && cfg_reg.sel == 4'h3) |=> fb_reg ==
      $past(ppr_sat_add(fb_i.analog_input_a, fb_i.analog_input_b)))
    else $error("feedback sum channel not taken");
  pos_sign_a: assert property (
    (sample_go && !cfg_reg.pol && fb_now > preset_i) |=> err_reg < 0)
    else $error("positive mode error sign wrong");
  neg_sign_a: assert property (
    (sample_go && cfg_reg.pol && fb_now > preset_i) |=> err_reg > 0)
    else $error("negative mode error sign wrong");
  one_sample_a: assert property (
    sample_go |=> (!sample_go) [*8])
    else $error("two samples too close");
  band_hold_a: assert property (
    (sample_go && in_band && ds_state != DS_RAMP) |=>
      cs_state == CS_IDLE && $stable(u_reg))
    else $error("output moved inside deviation limit");
  loss_clear_a: assert property (
    (ce_i && !fb_low) |=> loss_cnt_reg == 16'h0000)
    else $error("loss timer not cleared");
  loss_alarm_a: assert property (
    (ce_i && loss_set) |=> alarm_reg)
    else $error("loss alarm not raised");
  no_sleep_a: assert property (
    (ce_i && cfg_reg.en && ds_state == DS_HOLD
     && cfg_reg.sleep == 16'h0000) |=> ds_state == DS_RUN)
    else $error("hold kept with zero delay");
  sleep_zero_a: assert property (
    ds_state == DS_SLEEP |-> u_reg == 16'h0000)
    else $error("output nonzero in dormancy");
  wake_a: assert property (
    (cfg_reg.en && ds_state == DS_SLEEP && sample_go && wake_hit) |=>
      ds_state == DS_RUN && u_reg == 16'h0000)
    else $error("wake not taken from zero");

endmodule
`default_nettype wire

/* File: ppr_pkg.sv */
// Package of constants, types and helpers for the process PID regulator.
`default_nettype none
package ppr_pkg;

  // Clock rate and the 10 ms base tick that all slow timing is built on.
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Ticks in one tenth of a second, the unit of every long time setting.
  localparam int TICKS_PER_TENTH = 100 / TICK_MS;

  // Percentages are held in tenths: 16'h03E8 is 100.0 percent.
  localparam logic [15:0] PCT_FULL = 16'h03E8;
  // Output drop per base tick while ramping down into dormancy.
  localparam logic [15:0] RAMP_STEP = 16'h0001;
  // Gain is held in hundredths, so this divisor removes that scale.
  localparam logic [15:0] GAIN_ONE = 16'h0064;
  localparam int DIV_W = 40;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KP = 8'h04;
  localparam logic [7:0] OFS_TI = 8'h08;
  localparam logic [7:0] OFS_TD = 8'h0C;
  localparam logic [7:0] OFS_T = 8'h10;
  localparam logic [7:0] OFS_BAND = 8'h14;
  localparam logic [7:0] OFS_LTHR = 8'h18;
  localparam logic [7:0] OFS_LTIME = 8'h1C;
  localparam logic [7:0] OFS_WAKE = 8'h20;
  localparam logic [7:0] OFS_SLEEP = 8'h24;
  localparam logic [7:0] OFS_STAT = 8'h28;
  localparam logic [7:0] OFS_OUT = 8'h2C;
  localparam logic [7:0] OFS_FB = 8'h30;

  // Feedback inputs, each a percentage in tenths.
  typedef struct packed {
    logic [15:0] analog_input_a;
    logic [15:0] analog_input_b;
    logic [15:0] analog_input_c;
    logic [15:0] pulse_frequency_input;
    logic [15:0] bus_a;
    logic [15:0] bus_b;
  } ppr_fb_t;

  // Software settings; times in hundredths or tenths of a second.
  typedef struct packed {
    logic en;
    logic pol;
    logic [3:0] sel;
    logic [15:0] kp;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] t;
    logic [15:0] band;
    logic [15:0] loss_thr;
    logic [15:0] loss_time;
    logic [15:0] wake;
    logic [15:0] sleep;
  } ppr_cfg_t;

  localparam ppr_cfg_t CFG_RST = '{en: 1'b0, pol: 1'b0, sel: 4'h0,
    kp: 16'h0064, ti: 16'h0032, td: 16'h0000, t: 16'h000A,
    band: 16'h0000, loss_thr: 16'h0000, loss_time: 16'h000A,
    wake: 16'h0000, sleep: 16'h000A};

  typedef enum logic [3:0] {
    CS_IDLE = 4'h1, CS_DIVI = 4'h2, CS_DIVD = 4'h4, CS_DIVP = 4'h8
  } ppr_calc_t;

  typedef enum logic [3:0] {
    DS_RUN = 4'h1, DS_HOLD = 4'h2, DS_RAMP = 4'h4, DS_SLEEP = 4'h8
  } ppr_doze_t;

  // Sum of two percentages, saturated at full scale.
  function automatic logic [15:0] ppr_sat_add(input logic [15:0] a,
                                              input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, PCT_FULL}) ? PCT_FULL : s[15:0];
  endfunction

endpackage
`default_nettype wire

/* File: ppr_div.sv */
// Iterative signed-by-unsigned divider used for the PID terms.
`default_nettype none
module ppr_div
  import ppr_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic signed [W-1:0] num_i,
  input wire logic [15:0] den_i,
  output logic signed [W-1:0] quo_o,
  output logic done_o
);

  localparam int CW = $clog2(W + 1);

  logic [W-1:0] mag_reg;
  logic [16:0] rem_reg;
  logic [15:0] den_reg;
  logic [CW-1:0] cnt_reg;
  logic neg_reg;
  logic busy_reg;
  logic [16:0] trial;

  // One quotient bit per cycle; slow but tiny, and a sample is long.
  assign trial = {rem_reg[15:0], mag_reg[W-1]};
  assign quo_o = neg_reg ? -$signed(mag_reg) : $signed(mag_reg);

  // Restoring division on the magnitude; sign is put back at the end.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mag_reg <= '0;
      rem_reg <= '0;
      den_reg <= 16'h0001;
      cnt_reg <= '0;
      neg_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        mag_reg <= num_i[W-1] ? W'(-num_i) : num_i;
        rem_reg <= '0;
        den_reg <= (den_i == 16'h0000) ? 16'h0001 : den_i;
        cnt_reg <= CW'(W);
        neg_reg <= num_i[W-1];
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (trial >= {1'b0, den_reg}) begin
          rem_reg <= trial - {1'b0, den_reg};
          mag_reg <= {mag_reg[W-2:0], 1'b1};
        end else begin
          rem_reg <= trial;
          mag_reg <= {mag_reg[W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: ppr_plant.sv */
// Behavioural model of the process feedback sources seen by the regulator.
`default_nettype none
module ppr_plant
  import ppr_pkg::*;
(
  input wire logic [15:0] lvl_i,
  output ppr_fb_t fb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each channel gets a distinct level so a wrong selection cannot hide, except between sums 3 and 5, both full scale.
  // Levels stay on the 0..1000 tenths scale the regulator expects.
  assign fb_o = '{lvl_i, lvl_i >> 1, lvl_i >> 2, lvl_i + 16'h0001,
    lvl_i + 16'h0002, lvl_i + 16'h0003};
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the process PID regulator.
`default_nettype none
module tb;
  import ppr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 200;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic ref_v = 1'b0, e, pready, perr, fb_alarm, dormant, ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, r1;
  logic [15:0] preset = 16'h01F4, lvl = 16'h0320, freq;
  logic [15:0] exp_fb [9] = '{16'h0320, 16'h0190, 16'h00C8, 16'h03E8,
    16'h0258, 16'h03E8, 16'h0321, 16'h0322, 16'h0323};
  ppr_fb_t fb;
  int failures = 0, total_checks = 0, n;
  ////////////////////////////////////////////////////////////////////////
  ppr_plant plant (.lvl_i(lvl), .fb_o(fb));
  ppr_regulator #(.TICK_CYC(TC)) dut (.clk_i(clk), .rst_n_i(rst_n),
    .ce_i(ce), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .fb_i(fb), .preset_i(preset),
    .ref_valid_i(ref_v), .freq_cmd_o(freq), .fb_alarm_o(fb_alarm),
    .dormant_o(dormant));
  ////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1);
    // The slave inserts one wait state, so ready is seen at access edge 2.
    chk(32'(k), 32'h0000_0002);
    q = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic er;
    apb(1'b0, a, 32'h0, q, er);
  endtask
  // Waits whole sampling ticks, the period the note fixes.
  task automatic tk(input int t);
    repeat (t * TC) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Free-running clock and the watchdog that cuts a hang short.
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    finish_test();
  end
  // Main sequence; reset is released after six cycles.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_KP, r); chk(r, 32'h0000_0064);
    rd(OFS_T, r); chk(r, 32'h0000_000A);
    rd(OFS_LTIME, r); chk(r, 32'h0000_000A);
    apb(1'b0, 8'h34, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test reset done");
    // Preset and feedback come from separate sources here.
    wr(OFS_T, 32'h1);
    wr(OFS_BAND, 32'h3E8);
    wr(OFS_SLEEP, 32'h0);
    for (int s = 0; s < 9; s++) begin
      wr(OFS_CTRL, 32'((s << 2) | 1));
      tk(2);
      rd(OFS_FB, r); chk(r, {16'h0, exp_fb[s]});
    end
    rd(OFS_OUT, r); chk(r, 32'h0);
    chk({31'h0, dormant}, 32'h0);
    $display("test select done");
    wr(OFS_SLEEP, 32'h1);
    n = 0;
    while (dormant !== 1'b1 && n < 40 * TC) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, dormant}, 32'h1);
    chk({16'h0, freq}, 32'h0);
    // Channel first, so the waking sample already sees the new feedback.
    wr(OFS_CTRL, 32'h1);
    wr(OFS_WAKE, 32'h384);
    n = 0;
    while (dormant !== 1'b0 && n < 3 * TC) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, dormant}, 32'h0);
    $display("test dormancy done");
    wr(OFS_SLEEP, 32'h0);
    wr(OFS_BAND, 32'h0);
    wr(OFS_TI, 32'h3E8);
    wr(OFS_CTRL, 32'h3);
    tk(3);
    rd(OFS_OUT, r1); chk({31'h0, r1 != 0}, 32'h1);
    // Gain 1.00, deviation step from -300 to +300 tenths gives +600.
    chk(r1, 32'h0000_0258);
    chk({16'h0, freq}, 32'h0000_0258);
    wr(OFS_BAND, 32'h3E8);
    rd(OFS_OUT, r1);
    tk(3);
    rd(OFS_OUT, r); chk(r, r1);
    wr(OFS_BAND, 32'h0);
    wr(OFS_CTRL, 32'h1);
    tk(3);
    rd(OFS_OUT, r); chk({31'h0, r < r1}, 32'h1);
    chk(r, 32'h0000_0000);
    $display("test polarity done");
    ref_v <= 1'b1;
    wr(OFS_LTHR, 32'h384);
    wr(OFS_LTIME, 32'h2);
    tk(15);
    chk({31'h0, fb_alarm}, 32'h0);
    // Clock enable low must freeze the loss timer and the alarm.
    ce <= 1'b0;
    tk(25);
    chk({31'h0, fb_alarm}, 32'h0);
    ce <= 1'b1;
    tk(25);
    chk({31'h0, fb_alarm}, 32'h1);
    ref_v <= 1'b0;
    wr(OFS_STAT, 32'h1);
    @(posedge clk);
    chk({31'h0, fb_alarm}, 32'h0);
    $display("test loss done");
    finish_test();
  end
endmodule
`default_nettype wire
